// ==== hw/idc_top.v ====
// Interrupt distributor global control, banked control register and type register.
// How it works
// - Control register bit 0 is the global enable; bits 31 to 1 read zero.
// - With enable low, inputs are ignored and nothing is forwarded.
// - With enable high, inputs are sampled and pending interrupts forwarded.
// - All other register accesses except acknowledge reads, which return no interrupt, work normally while forwarding is off.
// - Set-pending and soft-generate writes mark pending even when disabled.
// - Clear-pending writes remove pending even when disabled.
// - A still-asserted level input becomes pending again once enabled.
// - End-of-interrupt writes remove active state even when disabled.
// - No interrupt becomes active while forwarding is disabled.
// - Soft interrupt pending clears only on activation, never by write.
// - Secure and non-secure control copies, chosen by access security.
// - Lock input high blocks writes to the secure control copy.
// - One shared type register reports security, lines, cpus, lockable count.
// - Lockable count field is reserved without security extensions.
// - Lockable count sits in type bits 15 to 11; zero means no lockdown.
// - Type bit 10 reports security extensions present.
// - Type bits 7 to 5 hold the cpu interface count minus one.
// - Type bits 4 to 0 hold N, with 32 times N plus one interrupts.
`timescale 1ns/10ps
`include "idc_defines.vh"
module idc_top #(
    parameter NUM_IRQ = 32,
    parameter NUM_SOFT = 16,
    parameter [4:0] LINES_N = 5'h00,
    parameter [2:0] CPU_M1 = 3'h0,
    parameter SEC_EXT = 1,
    parameter [4:0] LOCK_CNT = 5'h00
) (
    core_clk,
    arst_n,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_secure,
    reg_rdata,
    config_lock_input,
    irq_in,
    irq_level,
    fwd_en,
    cpu_irq
);
    input wire core_clk;
    input wire arst_n;
    input wire [7:0] reg_addr;
    input wire [31:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    input wire reg_secure;
    output reg [31:0] reg_rdata;
    input wire config_lock_input;
    input wire [NUM_IRQ-1:0] irq_in;
    input wire [NUM_IRQ-1:0] irq_level;
    output wire fwd_en;
    output reg cpu_irq;

    reg rst_s1_ff;
    reg rst_n_ff;
    reg lock_s1_ff;
    reg lock_ff;
    reg [NUM_IRQ-1:0] in_s1_ff;
    reg [NUM_IRQ-1:0] in_ff;
    reg en_sec_ff;
    reg en_ns_ff;
    reg [31:0] nxt_rdata;
    reg [31:0] type_val;
    reg [7:0] ack_id;
    wire [NUM_IRQ-1:0] pend;
    wire [NUM_IRQ-1:0] active;
    wire wr_ctrl;
    wire wr_set;
    wire wr_clr;
    wire wr_soft;
    wire wr_eoi;
    wire rd_ack;
    integer k;

    // ------------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------------

    // Reset is released through two flip-flops.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n_ff <= rst_s1_ff;
        end
    end

    // Lock pin and interrupt pins each pass two flip-flops.
    always @(posedge core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            lock_s1_ff <= 1'b0;
            lock_ff <= 1'b0;
            in_s1_ff <= {NUM_IRQ{1'b0}};
            in_ff <= {NUM_IRQ{1'b0}};
        end else begin
            lock_s1_ff <= config_lock_input;
            lock_ff <= lock_s1_ff;
            in_s1_ff <= irq_in;
            in_ff <= in_s1_ff;
        end
    end

    // ------------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------------

    // Write strobes per register; other registers ignore the enable.
    assign wr_ctrl = reg_wr && (reg_addr == `IDC_OFF_CTRL);
    assign wr_set = reg_wr && (reg_addr == `IDC_OFF_SET_PEND);
    assign wr_clr = reg_wr && (reg_addr == `IDC_OFF_CLR_PEND);
    assign wr_soft = reg_wr && (reg_addr == `IDC_OFF_SOFT_GEN);
    assign wr_eoi = reg_wr && (reg_addr == `IDC_OFF_EOI);
    assign rd_ack = reg_rd && (reg_addr == `IDC_OFF_ACK);

    // Banked control copies; without security all accesses use the secure copy.
    always @(posedge core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            en_sec_ff <= `IDC_CTRL_RESET;
            en_ns_ff <= `IDC_CTRL_RESET;
        end else if (wr_ctrl) begin
            if (reg_secure || SEC_EXT == 0) begin
                if (!(lock_ff && SEC_EXT != 0 && LOCK_CNT != 5'h00)) begin
                    en_sec_ff <= reg_wdata[`IDC_CTRL_EN_BIT];
                end
            end else begin
                en_ns_ff <= reg_wdata[`IDC_CTRL_EN_BIT];
            end
        end
    end

    // Forwarding runs while the secure copy enables it.
    assign fwd_en = en_sec_ff;

    // ------------------------------------------------------------------
    // Interrupt lines
    // ------------------------------------------------------------------

    genvar g;
    generate
        for (g = 0; g < NUM_IRQ; g = g + 1) begin : g_line
            idc_line u_line (
                .clk(core_clk),
                .rst_n(rst_n_ff),
                .fwd_en(fwd_en),
                .sync_in(in_ff[g]),
                .is_level(irq_level[g]),
                .is_soft(g < NUM_SOFT),
                .set_pend((wr_set && reg_wdata[g]) ||
                          (wr_soft && g < NUM_SOFT && reg_wdata[7:0] == g)),
                .clr_pend(wr_clr && reg_wdata[g]),
                .ack(rd_ack && ack_id == g),
                .eoi(wr_eoi && reg_wdata[7:0] == g),
                .pend_ff(pend[g]),
                .active_ff(active[g])
            );
        end
    endgenerate

    // Lowest numbered pending, inactive interrupt is offered for acknowledge.
    always @* begin
        ack_id = `IDC_ID_NONE;
        for (k = NUM_IRQ - 1; k >= 0; k = k - 1) begin
            if (pend[k] && !active[k]) begin
                ack_id = k[7:0];
            end
        end
        if (!fwd_en) begin
            ack_id = `IDC_ID_NONE;
        end
    end

    // Interrupt request towards the cpu interface.
    always @(posedge core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            cpu_irq <= 1'b0;
        end else begin
            cpu_irq <= fwd_en && (ack_id != `IDC_ID_NONE);
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    // Fixed type value; lockable field reserved without security.
    always @* begin
        type_val = 32'h0000_0000;
        type_val[`IDC_TYPE_LINES_LSB +: 5] = LINES_N;
        type_val[`IDC_TYPE_CPU_LSB +: 3] = CPU_M1;
        type_val[`IDC_TYPE_SEC_BIT] = (SEC_EXT != 0);
        type_val[`IDC_TYPE_LOCK_LSB +: 5] = (SEC_EXT != 0) ? LOCK_CNT : 5'h00;
    end

    // Read multiplexer; unmapped offsets read zero, type ignores writes.
    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (reg_addr)
            `IDC_OFF_CTRL: begin
                nxt_rdata[0] = (reg_secure || SEC_EXT == 0) ? en_sec_ff : en_ns_ff;
            end
            `IDC_OFF_TYPE: begin
                nxt_rdata = type_val;
            end
            `IDC_OFF_PEND: begin
                nxt_rdata[NUM_IRQ-1:0] = pend;
            end
            `IDC_OFF_ACTIVE: begin
                nxt_rdata[NUM_IRQ-1:0] = active;
            end
            `IDC_OFF_ACK: begin
                nxt_rdata[7:0] = ack_id;
            end
            `IDC_OFF_LEVEL: begin
                nxt_rdata[NUM_IRQ-1:0] = in_ff;
            end
            default: begin
                nxt_rdata = 32'h0000_0000;
            end
        endcase
    end

    // Read data stands in the cycle after the strobe only.
    always @(posedge core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= nxt_rdata;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule // idc_top

// ==== hw/idc_defines.vh ====
// Register offsets, field positions and reset values of the distributor control block.
`ifndef IDC_DEFINES_VH
`define IDC_DEFINES_VH
`define IDC_OFF_CTRL 8'h00
`define IDC_OFF_TYPE 8'h04
`define IDC_OFF_SET_PEND 8'h08
`define IDC_OFF_CLR_PEND 8'h0c
`define IDC_OFF_SOFT_GEN 8'h10
`define IDC_OFF_EOI 8'h14
`define IDC_OFF_PEND 8'h18
`define IDC_OFF_ACTIVE 8'h1c
`define IDC_OFF_ACK 8'h20
`define IDC_OFF_LEVEL 8'h24
`define IDC_CTRL_EN_BIT 0
`define IDC_CTRL_RESET 1'b0
`define IDC_TYPE_LINES_LSB 0
`define IDC_TYPE_CPU_LSB 5
`define IDC_TYPE_SEC_BIT 10
`define IDC_TYPE_LOCK_LSB 11
`define IDC_ID_NONE 8'hff
`endif

// ==== hw/idc_line.v ====
// One interrupt line: pending and active state with its input edge and level handling.
`timescale 1ns/10ps
module idc_line (
    clk,
    rst_n,
    fwd_en,
    sync_in,
    is_level,
    is_soft,
    set_pend,
    clr_pend,
    ack,
    eoi,
    pend_ff,
    active_ff
);
    input wire clk;
    input wire rst_n;
    input wire fwd_en;
    input wire sync_in;
    input wire is_level;
    input wire is_soft;
    input wire set_pend;
    input wire clr_pend;
    input wire ack;
    input wire eoi;
    output reg pend_ff;
    output reg active_ff;

    reg prev_ff;
    reg nxt_pend;
    reg nxt_active;
    wire rise;

    // Input edges are only seen while forwarding is on; the previous level is
    // tracked always, so a rise that happened while disabled is not seen later.
    assign rise = sync_in & ~prev_ff;

    // Next pending and active state; pending sets win over clears, end-of-interrupt wins over acknowledge.
    always @* begin
        nxt_pend = pend_ff;
        nxt_active = active_ff;
        if (clr_pend && !is_soft) begin
            nxt_pend = 1'b0;
        end
        if (ack && fwd_en && pend_ff) begin
            nxt_active = 1'b1;
            nxt_pend = 1'b0;
        end
        if (eoi) begin
            nxt_active = 1'b0;
        end
        if (set_pend) begin
            nxt_pend = 1'b1;
        end
        if (fwd_en && (is_level ? sync_in : rise) && !is_soft) begin
            nxt_pend = 1'b1;
        end
    end

    // State registers.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= 1'b0;
            active_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            pend_ff <= nxt_pend;
            active_ff <= nxt_active;
            prev_ff <= sync_in;
        end
    end
endmodule // idc_line

// ==== sim/idc_monitor.sv ====
// Checker of the distributor control block ports.
`timescale 1ns/10ps
module idc_monitor #(
    parameter [4:0] LOCK_CNT = 5'h00
) (
    input wire core_clk,
    input wire arst_n,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire reg_secure,
    input wire [31:0] reg_rdata,
    input wire config_lock_input,
    input wire fwd_en,
    input wire cpu_irq
);
    localparam [31:0] TYPE_V = {16'h0, LOCK_CNT, 11'h400};
    reg [3:0] lk_ff;
    wire cw = reg_wr && reg_addr == 8'h00;
    // Lock pin history, long enough to cover its synchroniser delay.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) lk_ff <= 4'h0;
        else lk_ff <= {lk_ff[2:0], config_lock_input};
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    ctrl_rsvd_a: assert property (
        reg_rd && reg_addr == 8'h00 |=> reg_rdata[31:1] == 31'h0) else $error("ctrl reserved");
    type_val_a: assert property (
        reg_rd && reg_addr == 8'h04 |=> reg_rdata == TYPE_V) else $error("type word wrong");
    no_fwd_off_a: assert property (
        !fwd_en ##1 !fwd_en |-> !cpu_irq) else $error("irq while disabled");
    en_write_a: assert property (
        cw && reg_secure && lk_ff == 4'h0 && !config_lock_input
        |=> fwd_en == $past(reg_wdata[0])) else $error("enable not written");
    lock_hold_a: assert property (
        LOCK_CNT != 5'h00 && cw && reg_secure && lk_ff == 4'hf
        |=> $stable(fwd_en)) else $error("locked write took");
    ns_write_a: assert property (
        reg_wr && !reg_secure |=> $stable(fwd_en)) else $error("ns write moved enable");
    other_keep_a: assert property (
        reg_wr && reg_addr != 8'h00 |=> $stable(fwd_en)) else $error("enable moved");
    rst_zero_a: assert property (
        $rose(arst_n) |-> !fwd_en ##1 !fwd_en) else $error("enable not reset");
    c_lock: cover property (cw && lk_ff == 4'hf);
    c_irq: cover property ($rose(cpu_irq));
    c_type: cover property (reg_rd && reg_addr == 8'h04);
endmodule // idc_monitor
bind idc_top idc_monitor #(.LOCK_CNT(LOCK_CNT)) mon_u (.core_clk(core_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_secure(reg_secure), .reg_rdata(reg_rdata), .config_lock_input(config_lock_input),
    .fwd_en(fwd_en), .cpu_irq(cpu_irq));

// ==== sim/idc_src_model.sv ====
// Model of the peripheral interrupt sources and the system lock pin.
`timescale 1ns/10ps
module idc_src_model (
    input wire clk,
    input wire [31:0] pin_req,
    input wire lock_req,
    output reg [31:0] irq_in = 32'h0,
    output reg config_lock_input = 1'h0
);
    // Sources move their lines just after a clock edge.
    always @(posedge clk) begin
        irq_in <= pin_req;
        config_lock_input <= lock_req;
    end
endmodule // idc_src_model

// ==== sim/tb_interrupt_distributor_control.sv ====
// Testbench of the distributor control block.
`timescale 1ns/10ps
module tb_interrupt_distributor_control;
    logic core_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, reg_secure = 0, lock_req = 0;
    logic cpu_irq, fwd_en, config_lock_input;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, pin_req = 32'h0, irq_level = 32'h0004_0000;
    logic [31:0] reg_rdata, irq_in;
    int bad_count = 0, n_tests = 0, cyc = 0;
    localparam [31:0] TYPE_V = 32'h0000_1c00;
    // Clock at 200 MHz.
    always #2.5 core_clk = ~core_clk;
    idc_src_model src_u (.clk(core_clk), .pin_req(pin_req), .lock_req(lock_req),
        .irq_in(irq_in), .config_lock_input(config_lock_input));
    idc_top #(.LOCK_CNT(5'h03)) dut_u (.core_clk(core_clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_secure(reg_secure), .reg_rdata(reg_rdata), .config_lock_input(config_lock_input),
        .irq_in(irq_in), .irq_level(irq_level), .fwd_en(fwd_en), .cpu_irq(cpu_irq));
    task automatic end_sim();
        $display("compares %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic s);
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        reg_secure <= s;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic s, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        reg_secure <= s;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic wait_pin(input logic [31:0] p);
        @(posedge core_clk);
        pin_req <= p;
        repeat (6) @(posedge core_clk);
        #1;
    endtask
    // A hang counts as a mismatch and closes the run.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            end_sim();
        end
    end
    // Main sequence of register tests.
    initial begin
        repeat (4) @(posedge core_clk);
        arst_n <= 1'h1;
        repeat (3) @(posedge core_clk);
        rd(8'h00, 1'h1, 32'h0);
        rd(8'h00, 1'h0, 32'h0);
        wr(8'h04, 32'hffffffff, 1'h1);
        rd(8'h04, 1'h1, TYPE_V);
        rd(8'h04, 1'h0, TYPE_V);
        $display("test reset done");
        wr(8'h00, 32'hffffffff, 1'h1);
        rd(8'h00, 1'h1, 32'h1);
        wr(8'h00, 32'h0, 1'h0);
        rd(8'h00, 1'h1, 32'h1);
        rd(8'h00, 1'h0, 32'h0);
        wr(8'h00, 32'h0, 1'h1);
        $display("test banking done");
        wait_pin(32'h0014_0000);
        wr(8'h08, 32'h0002_0000, 1'h1);
        wr(8'h10, 32'h3, 1'h1);
        rd(8'h18, 1'h1, 32'h0002_0008);
        wr(8'h0c, 32'h0002_0008, 1'h1);
        rd(8'h18, 1'h1, 32'h8);
        chk(cpu_irq, 32'h0);
        rd(8'h1c, 1'h1, 32'h0);
        $display("test disabled done");
        wr(8'h00, 32'h1, 1'h1);
        wait_pin(32'h0034_0000);
        chk({31'h0, fwd_en}, 32'h1);
        chk(cpu_irq, 32'h1);
        rd(8'h24, 1'h1, 32'h0034_0000);
        rd(8'h18, 1'h1, 32'h0024_0008);
        rd(8'h20, 1'h1, 32'h3);
        rd(8'h18, 1'h1, 32'h0024_0000);
        rd(8'h1c, 1'h1, 32'h8);
        wr(8'h00, 32'h0, 1'h1);
        wr(8'h14, 32'h3, 1'h1);
        rd(8'h1c, 1'h1, 32'h0);
        chk(cpu_irq, 32'h0);
        $display("test forwarding done");
        @(posedge core_clk);
        lock_req <= 1'h1;
        repeat (8) @(posedge core_clk);
        wr(8'h00, 32'h1, 1'h1);
        rd(8'h00, 1'h1, 32'h0);
        wr(8'h00, 32'h1, 1'h0);
        rd(8'h00, 1'h0, 32'h1);
        wr(8'h3c, 32'hffffffff, 1'h1);
        rd(8'h3c, 1'h1, 32'h0);
        $display("test lock done");
        end_sim();
    end
endmodule // tb_interrupt_distributor_control
